// file: core/link_byte_rx.sv
// Serial byte receiver running on the link clock during a load frame.
// Assumes the link clock may stop outside frames; a low frame level clears the bit count only on a link clock edge.
`timescale 1ns/10ps
`default_nettype none
module link_byte_rx (
	// Link clock and reset
	input  wire logic link_clk,
	input  wire logic rst_n,
	// Serial link
	input  wire logic link_frame,
	input  wire logic link_data,
	// To core
	link_if.rx        lk
);
	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
		logic [7:0] byte_v;
		logic       tog;
	} rx_st_t;

	rx_st_t s_r;
	rx_st_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!link_frame) begin
			s_nxt.cnt = 3'h0;
		end else begin
			s_nxt.sh = {s_r.sh[5:0], link_data};
			s_nxt.cnt = s_r.cnt + 3'h1;
			// Byte stays put for eight link clocks, long enough to cross.
			if (s_r.cnt == 3'h7) begin
				s_nxt.byte_v = {s_r.sh, link_data};
				s_nxt.tog = ~s_r.tog;
			end
		end
	end

	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lk.rx_byte   = s_r.byte_v;
	assign lk.rx_toggle = s_r.tog;
endmodule // link_byte_rx
`default_nettype wire

// file: core/link_if.sv
// Carrier between the link-side byte receiver and the core logic.
// The byte is held stable while the toggle crosses into the system clock.
`timescale 1ns/10ps
`default_nettype none
interface link_if;
	logic [7:0] rx_byte;
	logic       rx_toggle;
	modport rx   (output rx_byte, output rx_toggle);
	modport core (input rx_byte, input rx_toggle);
endinterface
`default_nettype wire

// file: core/repeater_config_source_select.sv
// Configuration source selection: strap decode, register file, loader.
// Assumes strap pins arrive as three threshold comparator outputs each.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module repeater_config_source_select #(
	parameter int POR_WAIT     = repeater_pkg::POR_CYCLES,
	parameter int LOAD_TIMEOUT = repeater_pkg::LOAD_CYCLES
) (
	// System clock and reset
	input  wire logic                                 sys_clk,
	input  wire logic                                 rst_n,
	// Link clock domain
	input  wire logic                                 link_clk,
	input  wire logic                                 link_frame,
	input  wire logic                                 link_data,
	// Mode pin comparators: bit 1 above high, bit 0 above low
	input  wire logic [1:0]                           smbus_mode_select,
	// Strap pin comparators: bits above 0.8, 0.5, 0.2
	input  wire logic [repeater_pkg::NUM_PINS-1:0][2:0] strap_cmp,
	input  wire logic                                 power_down_pin,
	input  wire logic [repeater_pkg::NUM_CH-1:0]      signal_detect_raw,
	// Register port
	input  wire logic [repeater_pkg::ADDR_W-1:0]      reg_addr,
	input  wire logic [repeater_pkg::DATA_W-1:0]      reg_wdata,
	input  wire logic                                 reg_wr,
	input  wire logic                                 reg_rd,
	output logic      [repeater_pkg::DATA_W-1:0]      reg_rdata,
	// Channel settings
	output logic      [repeater_pkg::NUM_CH-1:0][1:0] chan_eq,
	output logic      [repeater_pkg::NUM_CH-1:0][2:0] chan_swing,
	output logic      [repeater_pkg::NUM_CH-1:0][1:0] chan_term,
	output logic      [repeater_pkg::NUM_CH-1:0]      chan_enable,
	output logic      [1:0]                           sd_threshold,
	output logic      [3:0]                           slave_address_inputs,
	// Status and bus clock
	output logic      [1:0]                           cfg_mode,
	output logic                                      device_ready,
	output logic                                      load_hung,
	output logic                                      scl_out,
	output logic                                      scl_oe
);
	import repeater_pkg::*;

	localparam int POR_W = $clog2(POR_WAIT + 1);
	localparam int LD_W  = $clog2(LOAD_TIMEOUT + 1);
	localparam int DIV_W = $clog2(SCL_HALF_CYCLES + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_WAIT - 1);
	localparam logic [LD_W-1:0]  LD_LAST  = LD_W'(LOAD_TIMEOUT - 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCL_HALF_CYCLES - 1);

	typedef struct packed {
		logic [1:0]                    mode_s1;
		logic [1:0]                    mode_s2;
		logic [NUM_PINS*3-1:0]         pin_s1;
		logic [NUM_PINS*3-1:0]         pin_s2;
		logic [NUM_CH-1:0]             sd_s1;
		logic [NUM_CH-1:0]             sd_s2;
		logic                          pd_s1;
		logic                          pd_s2;
		logic                          tog_s1;
		logic                          tog_s2;
		logic                          tog_seen;
		logic [NUM_PINS-1:0][1:0]      held;
		logic [NUM_CH-1:0][DATA_W-1:0] ch;
		logic [DATA_W-1:0]             glob;
		logic [DATA_W-1:0]             ovr;
		logic                          rx_ovr_lat;
		logic                          sd_ovr_lat;
		logic [POR_W-1:0]              por_cnt;
		logic                          ready;
		ld_state_t                     ld;
		logic [LD_W-1:0]               ld_cnt;
		logic [7:0]                    ld_addr;
		logic                          ld_have_addr;
		logic [DIV_W-1:0]              scl_div;
		logic                          scl_low;
		logic [DATA_W-1:0]             rdata;
		mode_t                         mode;
		logic [NUM_CH-1:0][1:0]        eq;
		logic [NUM_CH-1:0][2:0]        swing;
		logic [NUM_CH-1:0][1:0]        term;
		logic [NUM_CH-1:0]             en;
		logic [1:0]                    sdth;
		logic [3:0]                    saddr;
	} core_st_t;

	core_st_t s_r;
	core_st_t s_nxt;

	link_if lk ();

	link_byte_rx u_rx (
		.link_clk   (link_clk),
		.rst_n      (rst_n),
		.link_frame (link_frame),
		.link_data  (link_data),
		.lk         (lk.rx)
	);

	// Live decode of each strap pin from its synchronised comparators.
	logic [NUM_PINS-1:0][1:0] pin_lvl;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_lvl
			always_comb begin
				if (s_r.pin_s2[gi*3+2]) begin
					pin_lvl[gi] = LVL_1;
				end else if (s_r.pin_s2[gi*3+1]) begin
					pin_lvl[gi] = LVL_F;
				end else if (s_r.pin_s2[gi*3]) begin
					pin_lvl[gi] = LVL_R;
				end else begin
					pin_lvl[gi] = LVL_0;
				end
			end
		end
	endgenerate

	// Two swing straps give levels 1 to 7; higher combinations saturate.
	function automatic logic [2:0] swing_map(input logic [1:0] hi,
		input logic [1:0] lo);
		logic [4:0] sum;
		sum = {1'b0, hi, 2'b00} + {3'b000, lo} + 5'h01;
		swing_map = (sum > 5'h07) ? 3'h7 : sum[2:0];
	endfunction

	// Threshold strap level to register code.
	function automatic logic [1:0] sdth_map(input logic [1:0] lvl);
		case (lvl)
			LVL_0: sdth_map = 2'b10;
			LVL_R: sdth_map = 2'b01;
			LVL_F: sdth_map = 2'b00;
			default: sdth_map = 2'b11;
		endcase
	endfunction

	mode_t      raw_mode;
	logic       byte_evt;
	logic [1:0] rx_lvl;
	logic       ch_hit;
	logic [2:0] ch_idx;

	always_comb begin
		if (s_r.mode_s2[1]) begin
			raw_mode = MODE_SLAVE;
		end else if (!s_r.mode_s2[0]) begin
			raw_mode = MODE_PIN;
		end else begin
			raw_mode = MODE_MASTER;
		end
	end

	assign byte_evt = s_r.tog_s2 ^ s_r.tog_seen;
	assign ch_hit   = (reg_addr[7:3] == REG_CH_BASE[7:3]);
	assign ch_idx   = reg_addr[2:0];

	always_comb begin
		s_nxt = s_r;
		// Synchronisers; first stages feed only second stages.
		s_nxt.mode_s1 = smbus_mode_select;
		s_nxt.mode_s2 = s_r.mode_s1;
		s_nxt.pin_s1 = strap_cmp;
		s_nxt.pin_s2 = s_r.pin_s1;
		s_nxt.sd_s1 = signal_detect_raw;
		s_nxt.sd_s2 = s_r.sd_s1;
		s_nxt.pd_s1 = power_down_pin;
		s_nxt.pd_s2 = s_r.pd_s1;
		s_nxt.tog_s1 = lk.rx_toggle;
		s_nxt.tog_s2 = s_r.tog_s1;
		s_nxt.tog_seen = s_r.tog_s2;

		// Power-on wait before anything is answered.
		if (!s_r.ready) begin
			s_nxt.por_cnt = s_r.por_cnt + POR_W'(1);
			if (s_r.por_cnt == POR_LAST) begin
				s_nxt.ready = 1'b1;
			end
		end

		// Effective mode; a finished load reverts to slave operation.
		if (raw_mode == MODE_MASTER && s_r.ld == LD_DONE) begin
			s_nxt.mode = MODE_SLAVE;
		end else begin
			s_nxt.mode = raw_mode;
		end

		if (s_r.mode == MODE_PIN) begin
			s_nxt.held = pin_lvl;
			s_nxt.rx_ovr_lat = 1'b0;
			s_nxt.sd_ovr_lat = 1'b0;
		end else if (s_r.mode == MODE_SLAVE) begin
			if (s_r.ovr[OVR_RECEIVER_DETECT_PIN_BIT]) begin
				s_nxt.rx_ovr_lat = 1'b1;
			end
			if (s_r.ovr[OVR_SDTH_BIT]) begin
				s_nxt.sd_ovr_lat = 1'b1;
			end
		end

		// Software writes; settings wait for the enable bit.
		if (reg_wr && s_r.ready) begin
			if (reg_addr == REG_GLOBAL) begin
				s_nxt.glob = reg_wdata;
			end else if (s_r.glob[GLB_REG_EN_BIT]) begin
				if (reg_addr == REG_OVR) begin
					s_nxt.ovr = reg_wdata;
				end else if (ch_hit) begin
					s_nxt.ch[ch_idx] = reg_wdata;
				end
			end
		end

		// Read data stand for exactly the cycle after the strobe.
		s_nxt.rdata = '0;
		if (reg_rd && s_r.ready) begin
			if (reg_addr == REG_GLOBAL) begin
				s_nxt.rdata = s_r.glob;
			end else if (reg_addr == REG_OVR) begin
				s_nxt.rdata = s_r.ovr;
			end else if (reg_addr == REG_SD_STAT) begin
				s_nxt.rdata = s_r.sd_s2;
			end else if (reg_addr == REG_STATUS) begin
				s_nxt.rdata = {s_r.ready, 2'b00, s_r.mode, s_r.ld};
			end else if (reg_addr == REG_SADDR) begin
				s_nxt.rdata = {4'h0, s_r.saddr};
			end else if (ch_hit) begin
				s_nxt.rdata = s_r.ch[ch_idx];
			end
		end

		// Image loader: address byte, value byte, until the end marker.
		case (s_r.ld)
			LD_IDLE: begin
				s_nxt.ld_cnt = '0;
				s_nxt.ld_have_addr = 1'b0;
				s_nxt.scl_div = '0;
				s_nxt.scl_low = 1'b0;
				if (s_r.ready && raw_mode == MODE_MASTER) begin
					s_nxt.ld = LD_LOAD;
				end
			end
			LD_LOAD: begin
				if (s_r.scl_div == DIV_LAST) begin
					s_nxt.scl_div = '0;
					s_nxt.scl_low = ~s_r.scl_low;
				end else begin
					s_nxt.scl_div = s_r.scl_div + DIV_W'(1);
				end
				s_nxt.ld_cnt = s_r.ld_cnt + LD_W'(1);
				if (raw_mode != MODE_MASTER) begin
					s_nxt.ld = LD_IDLE;
					s_nxt.scl_low = 1'b0;
				end else if (byte_evt) begin
					s_nxt.ld_cnt = '0;
					if (!s_r.ld_have_addr) begin
						if (lk.rx_byte == LOAD_END_ADDR) begin
							s_nxt.ld = LD_DONE;
							s_nxt.scl_low = 1'b0;
						end else begin
							s_nxt.ld_addr = lk.rx_byte;
							s_nxt.ld_have_addr = 1'b1;
						end
					end else begin
						s_nxt.ld_have_addr = 1'b0;
						if (s_r.ld_addr == REG_GLOBAL) begin
							s_nxt.glob = lk.rx_byte;
						end else if (s_r.ld_addr == REG_OVR) begin
							s_nxt.ovr = lk.rx_byte;
						end else if (s_r.ld_addr[7:3] == REG_CH_BASE[7:3]) begin
							s_nxt.ch[s_r.ld_addr[2:0]] = lk.rx_byte;
						end
					end
				end else if (s_r.ld_cnt == LD_LAST) begin
					s_nxt.ld = LD_HUNG;
					s_nxt.scl_low = 1'b0;
				end
			end
			LD_DONE, LD_HUNG: begin
				s_nxt.scl_low = 1'b0;
				if (raw_mode != MODE_MASTER) begin
					s_nxt.ld = LD_IDLE;
				end
			end
			default: begin
				s_nxt.ld = LD_IDLE;
			end
		endcase

		// Channel settings; power-down only gates outputs.
		rx_lvl = s_r.rx_ovr_lat ? s_r.ovr[OVR_RECEIVER_DETECT_PIN_LSB +: 2]
			: pin_lvl[PIN_RECEIVER_DETECT_PIN];
		for (int c = 0; c < NUM_CH; c++) begin
			if (s_r.mode == MODE_PIN) begin
				if (c < NUM_CH / 2) begin
					s_nxt.eq[c] = s_r.held[PIN_EQA];
					s_nxt.swing[c] = swing_map(s_r.held[PIN_SWA1],
						s_r.held[PIN_SWA0]);
				end else begin
					s_nxt.eq[c] = s_r.held[PIN_EQB];
					s_nxt.swing[c] = swing_map(s_r.held[PIN_SWB1],
						s_r.held[PIN_SWB0]);
				end
				s_nxt.term[c] = s_r.held[PIN_RECEIVER_DETECT_PIN];
			end else begin
				s_nxt.eq[c] = s_r.ch[c][CH_EQ_LSB +: 2];
				s_nxt.swing[c] = s_r.ch[c][CH_SWING_LSB +: 3];
				s_nxt.term[c] = s_r.ch[c][CH_TERM_DIS] ? LVL_0 : rx_lvl;
			end
			if (s_r.pd_s2) begin
				s_nxt.term[c] = LVL_0;
			end
			s_nxt.en[c] = ~s_r.pd_s2;
		end

		if (s_r.mode == MODE_PIN) begin
			s_nxt.sdth = sdth_map(s_r.held[PIN_SDTH]);
		end else if (s_r.sd_ovr_lat) begin
			s_nxt.sdth = s_r.ovr[OVR_SDTH_LSB +: 2];
		end else begin
			s_nxt.sdth = sdth_map(pin_lvl[PIN_SDTH]);
		end

		if (s_r.mode != MODE_PIN) begin
			s_nxt.saddr = {pin_lvl[PIN_SWB1][1], pin_lvl[PIN_SWA1][1],
				pin_lvl[PIN_EQB][1], pin_lvl[PIN_EQA][1]};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.glob <= GLOBAL_RST;
			s_r.ovr <= OVR_RST;
			s_r.ch <= {NUM_CH{CH_RST}};
			s_r.ld <= LD_IDLE;
			s_r.mode <= MODE_PIN;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata            = s_r.rdata;
	assign chan_eq              = s_r.eq;
	assign chan_swing           = s_r.swing;
	assign chan_term            = s_r.term;
	assign chan_enable          = s_r.en;
	assign sd_threshold         = s_r.sdth;
	assign slave_address_inputs = s_r.saddr;
	assign cfg_mode             = s_r.mode;
	assign device_ready         = s_r.ready;
	assign load_hung            = (s_r.ld == LD_HUNG);
	assign scl_out              = 1'b0;
	assign scl_oe               = s_r.scl_low;
endmodule // repeater_config_source_select
`default_nettype wire

// file: core/repeater_pkg.sv
// Shared constants, codes and register layout for the configuration source
// selection block of the eight-channel repeater.
// Assumes a 10 MHz system clock and 8-bit register data.
package repeater_pkg;

	localparam int NUM_CH   = 8;
	localparam int NUM_PINS = 8;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;

	// Strap pin positions inside the comparator bundle.
	localparam int PIN_EQA   = 0;
	localparam int PIN_EQB   = 1;
	localparam int PIN_SWA1  = 2;
	localparam int PIN_SWA0  = 3;
	localparam int PIN_SWB1  = 4;
	localparam int PIN_SWB0  = 5;
	localparam int PIN_RECEIVER_DETECT_PIN = 6;
	localparam int PIN_SDTH  = 7;

	// Register offsets.
	localparam logic [ADDR_W-1:0] REG_GLOBAL  = 8'h06;
	localparam logic [ADDR_W-1:0] REG_OVR     = 8'h08;
	localparam logic [ADDR_W-1:0] REG_SD_STAT = 8'h0A;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h0B;
	localparam logic [ADDR_W-1:0] REG_SADDR   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_CH_BASE = 8'h10;

	// Field positions.
	localparam int GLB_REG_EN_BIT = 3;
	localparam int OVR_RECEIVER_DETECT_PIN_BIT  = 7;
	localparam int OVR_SDTH_BIT   = 6;
	localparam int OVR_RECEIVER_DETECT_PIN_LSB  = 2;
	localparam int OVR_SDTH_LSB   = 0;
	localparam int CH_EQ_LSB      = 0;
	localparam int CH_SWING_LSB   = 2;
	localparam int CH_TERM_DIS    = 5;

	// Values after reset.
	localparam logic [DATA_W-1:0] GLOBAL_RST = 8'h00;
	localparam logic [DATA_W-1:0] OVR_RST    = 8'h08;
	localparam logic [DATA_W-1:0] CH_RST     = 8'h06;

	// End marker of the configuration image.
	localparam logic [7:0] LOAD_END_ADDR = 8'hFF;

	typedef enum logic [1:0] {
		LVL_0 = 2'b00,
		LVL_R = 2'b01,
		LVL_F = 2'b10,
		LVL_1 = 2'b11
	} level_t;

	typedef enum logic [1:0] {
		MODE_PIN    = 2'b00,
		MODE_SLAVE  = 2'b01,
		MODE_MASTER = 2'b10
	} mode_t;

	typedef enum logic [2:0] {
		LD_IDLE = 3'b000,
		LD_LOAD = 3'b001,
		LD_DONE = 3'b010,
		LD_HUNG = 3'b011
	} ld_state_t;

	// Timing.
	localparam int SYS_CLK_HZ      = 10_000_000;
	localparam int POR_TIME_MS     = 500;
	localparam int POR_CYCLES      = POR_TIME_MS * (SYS_CLK_HZ / 1000);
	localparam int LOAD_TIMEOUT_MS = 50;
	localparam int LOAD_CYCLES     = LOAD_TIMEOUT_MS * (SYS_CLK_HZ / 1000);
	localparam int SCL_NOM_KHZ     = 400;
	localparam int SCL_HALF_CYCLES =
		(SYS_CLK_HZ / 1000 + 2 * SCL_NOM_KHZ - 1) / (2 * SCL_NOM_KHZ);

endpackage

// file: tb/link_image_source.sv
// Behavioural source of configuration image bytes on the serial link.
// Assumes the receiver samples on the rising link clock within a frame.
`timescale 1ns/10ps
`default_nettype none
module link_image_source (
	// Serial link
	output logic link_clk,
	output logic link_frame,
	output logic link_data
);
	initial begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_data = 1'b1;
	end
	// The clock stands still between frames and the idle data line flips.
	task automatic send_byte(input logic [7:0] b);
		#37;
		link_frame = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			link_data = b[i];
			#80 link_clk = 1'b1;
			#80 link_clk = 1'b0;
		end
		link_frame = 1'b0;
		link_data = ~b[0];
		#480;
	endtask
endmodule // link_image_source
`default_nettype wire

// file: tb/repeater_config_source_select_properties.sv
// Port-level checks for the configuration source selection block.
// Assumes it is bound to that block and sees only the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module repeater_config_source_select_properties #(
	parameter int POR_WAIT     = 20,
	parameter int LOAD_TIMEOUT = 200
) (
	// Clocks, reset and link
	input wire logic                                   sys_clk,
	input wire logic                                   rst_n,
	input wire logic                                   link_clk,
	input wire logic                                   link_frame,
	input wire logic                                   link_data,
	// Pins
	input wire logic [1:0]                             smbus_mode_select,
	input wire logic [repeater_pkg::NUM_PINS-1:0][2:0] strap_cmp,
	input wire logic                                   power_down_pin,
	input wire logic [repeater_pkg::NUM_CH-1:0]        signal_detect_raw,
	// Register port
	input wire logic [repeater_pkg::ADDR_W-1:0]        reg_addr,
	input wire logic [repeater_pkg::DATA_W-1:0]        reg_wdata,
	input wire logic                                   reg_wr,
	input wire logic                                   reg_rd,
	input wire logic [repeater_pkg::DATA_W-1:0]        reg_rdata,
	// Outputs
	input wire logic [repeater_pkg::NUM_CH-1:0][1:0]   chan_eq,
	input wire logic [repeater_pkg::NUM_CH-1:0][2:0]   chan_swing,
	input wire logic [repeater_pkg::NUM_CH-1:0][1:0]   chan_term,
	input wire logic [repeater_pkg::NUM_CH-1:0]        chan_enable,
	input wire logic [1:0]                             sd_threshold,
	input wire logic [3:0]                             slave_address_inputs,
	input wire logic [1:0]                             cfg_mode,
	input wire logic                                   device_ready,
	input wire logic                                   load_hung,
	input wire logic                                   scl_out,
	input wire logic                                   scl_oe
);
	import repeater_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	int unsigned since_r;
	logic [7:0]  run_r;
	logic        last_oe_r;
	logic        armed_r;
	// Only falling bus clock edges (scl_oe rising) are timed, since a release may cut a phase.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_r   <= 0;
			run_r     <= 8'h00;
			last_oe_r <= 1'b0;
			armed_r   <= 1'b0;
		end else begin
			if (since_r < POR_WAIT + 8)
				since_r <= since_r + 1;
			last_oe_r <= scl_oe;
			run_r <= (scl_oe != last_oe_r) ? 8'h00 :
				(run_r == 8'hFF) ? run_r : run_r + 8'h01;
			armed_r <= (cfg_mode == 2'h2) && (armed_r || scl_oe != last_oe_r);
		end
	end
	function automatic logic [1:0] lvl(input logic [2:0] c);
		return {c[1], c[2] | (c[0] & ~c[1])};
	endfunction
	function automatic logic [2:0] swg(input logic [2:0] h, input logic [2:0] l);
		logic [4:0] s;
		s = {1'b0, lvl(h), 2'h0} + {3'h0, lvl(l)} + 5'h1;
		return (s > 5'h7) ? 3'h7 : s[2:0];
	endfunction
	sequence pin_settled;
		(device_ready && cfg_mode == 2'h0 && $stable(strap_cmp))[*5];
	endsequence
	sequence slave_settled;
		(device_ready && cfg_mode == 2'h1 && $stable(strap_cmp))[*5];
	endsequence
	ready_late_a: assert property (since_r + 1 < POR_WAIT |-> !device_ready)
		else $error("ready before the power-on wait");
	ready_soon_a: assert property (since_r >= POR_WAIT + 2 |-> device_ready)
		else $error("ready missing after the power-on wait");
	rdata_idle_a: assert property (!(reg_rd && device_ready) |=> reg_rdata == 8'h00)
		else $error("read data without an accepted read");
	pin_mode_a: assert property ((device_ready && smbus_mode_select == 2'h0)[*5]
		|-> cfg_mode == 2'h0) else $error("pin mode not selected");
	slave_mode_a: assert property ((device_ready && smbus_mode_select[1])[*5]
		|-> cfg_mode == 2'h1) else $error("slave mode not selected");
	pin_eq_a: assert property (pin_settled |-> chan_eq[0] == lvl(strap_cmp[PIN_EQA])
		&& chan_eq[NUM_CH-1] == lvl(strap_cmp[PIN_EQB]))
		else $error("pin equalization differs from straps");
	pin_swing_a: assert property (pin_settled |->
		chan_swing[0] == swg(strap_cmp[PIN_SWA1], strap_cmp[PIN_SWA0]))
		else $error("pin swing differs from straps");
	slave_addr_a: assert property (slave_settled |-> slave_address_inputs ==
		{strap_cmp[PIN_SWB1][1], strap_cmp[PIN_SWA1][1],
		strap_cmp[PIN_EQB][1], strap_cmp[PIN_EQA][1]})
		else $error("slave address differs from straps");
	power_off_a: assert property (power_down_pin[*5] |->
		chan_enable == 8'h00 && chan_term == '0) else $error("power down ignored");
	slave_release_a: assert property (cfg_mode == 2'h1 |-> !scl_oe)
		else $error("bus clock held in slave mode");
	hung_release_a: assert property (load_hung |-> !scl_oe)
		else $error("bus clock held after a failed load");
	scl_half_a: assert property (scl_oe && !last_oe_r && armed_r |->
		run_r == SCL_HALF_CYCLES - 1) else $error("bus clock half period wrong");
endmodule // repeater_config_source_select_properties
bind repeater_config_source_select repeater_config_source_select_properties #(
	.POR_WAIT(POR_WAIT), .LOAD_TIMEOUT(LOAD_TIMEOUT)
) repeater_config_source_select_properties_inst (
	.sys_clk, .rst_n, .link_clk, .link_frame, .link_data, .smbus_mode_select,
	.strap_cmp, .power_down_pin, .signal_detect_raw, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .chan_eq, .chan_swing, .chan_term,
	.chan_enable, .sd_threshold, .slave_address_inputs, .cfg_mode,
	.device_ready, .load_hung, .scl_out, .scl_oe
);
`default_nettype wire

// file: tb/test_repeater_config_source_select.sv
// Self-checking bench for the configuration source selection block.
// Assumes the image source model drives the link and straps are comparators.
`timescale 1ns/10ps
`default_nettype none
module test_repeater_config_source_select;
	import repeater_pkg::*;
	localparam int POR_SIM = 20;
	localparam int LOAD_SIM = 200;
	logic sys_clk, rst_n, link_clk, link_frame, link_data, power_down_pin;
	logic [1:0] smbus_mode_select, sd_threshold, cfg_mode;
	logic [NUM_PINS-1:0][2:0] strap_cmp;
	logic [NUM_CH-1:0] signal_detect_raw, chan_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, device_ready, load_hung, scl_out, scl_oe;
	logic [NUM_CH-1:0][1:0] chan_eq, chan_term;
	logic [NUM_CH-1:0][2:0] chan_swing;
	logic [3:0] slave_address_inputs;
	logic [1:0] lv [NUM_PINS];
	logic [7:0] val [NUM_CH];
	int error_cnt, n_tests;
	repeater_config_source_select #(.POR_WAIT(POR_SIM), .LOAD_TIMEOUT(LOAD_SIM))
	repeater_config_source_select_inst (.sys_clk, .rst_n, .link_clk,
		.link_frame, .link_data, .smbus_mode_select, .strap_cmp,
		.power_down_pin, .signal_detect_raw, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .chan_eq, .chan_swing, .chan_term, .chan_enable,
		.sd_threshold, .slave_address_inputs, .cfg_mode, .device_ready,
		.load_hung, .scl_out, .scl_oe);
	link_image_source link_image_source_inst (.link_clk, .link_frame, .link_data);
	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;
	function automatic logic [2:0] cmp_of(input logic [1:0] l);
		return (l == 2'h0) ? 3'h0 : (l == 2'h1) ? 3'h1 : (l == 2'h2) ? 3'h3 : 3'h7;
	endfunction
	function automatic logic [7:0] pin_sw(input int c);
		int s;
		s = 4 * lv[c < 4 ? PIN_SWA1 : PIN_SWB1] + lv[c < 4 ? PIN_SWA0 : PIN_SWB0] + 1;
		return (s > 7) ? 8'h07 : 8'(s);
	endfunction
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(what, exp, reg_rdata);
	endtask
	task automatic settle();
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	// Selector 0 waits for ready, 1 for a hung load, 4 to 6 for a mode.
	task automatic wait_st(input int sel, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			if (sel == 0 ? device_ready === 1'b1 : sel == 1 ? load_hung === 1'b1
				: cfg_mode === sel[1:0])
				break;
			@(negedge sys_clk);
		end
		if (i == lim) begin
			error_cnt++;
			$display("FAIL wait %0d expected 1 seen 0", sel);
			final_report();
		end
	endtask
	initial begin
		void'($urandom(11));
		rst_n = 1'b0;
		smbus_mode_select = 2'h0;
		strap_cmp = '0;
		power_down_pin = 1'b0;
		signal_detect_raw = 8'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(REG_CH_BASE, 8'h00, "early read");
		wait_st(0, POR_SIM + 10);
		rd(REG_CH_BASE, CH_RST, "channel reset");
		rd(REG_OVR, OVR_RST, "override reset");
		rd(REG_GLOBAL, GLOBAL_RST, "global reset");
		rd(8'h3F, 8'h00, "unmapped read");
		$display("test reset done");
		for (int t = 0; t < 5; t++) begin
			@(posedge sys_clk);
			for (int p = 0; p < NUM_PINS; p++) begin
				lv[p] = (t < 2) ? 2'(3 * (1 - t)) : 2'($urandom_range(3));
				strap_cmp[p] <= cmp_of(lv[p]);
			end
			signal_detect_raw <= 8'($urandom);
			settle();
			chk("pin mode", {6'h00, MODE_PIN}, {6'h00, cfg_mode});
			chk("threshold", {6'h00, ~^lv[PIN_SDTH], lv[PIN_SDTH][0]}, {6'h00, sd_threshold});
			for (int c = 0; c < NUM_CH; c++) begin
				chk("pin eq", {6'h00, lv[c < 4 ? PIN_EQA : PIN_EQB]}, {6'h00, chan_eq[c]});
				chk("pin swing", pin_sw(c), {5'h00, chan_swing[c]});
				chk("pin term", {6'h00, lv[PIN_RECEIVER_DETECT_PIN]}, {6'h00, chan_term[c]});
			end
			rd(REG_SD_STAT, signal_detect_raw, "detect status");
		end
		$display("test pin mode done");
		@(posedge sys_clk);
		smbus_mode_select <= 2'h2;
		settle();
		chk("slave mode", {6'h00, MODE_SLAVE}, {6'h00, cfg_mode});
		chk("slave eq", {6'h00, CH_RST[1:0]}, {6'h00, chan_eq[5]});
		chk("slave swing", {5'h00, CH_RST[4:2]}, {5'h00, chan_swing[5]});
		chk("address", {4'h0, lv[PIN_SWB1][1], lv[PIN_SWA1][1], lv[PIN_EQB][1],
			lv[PIN_EQA][1]}, {4'h0, slave_address_inputs});
		wr(REG_CH_BASE + 8'h01, 8'h1F);
		rd(REG_CH_BASE + 8'h01, CH_RST, "locked write");
		wr(REG_GLOBAL, 8'(1 << GLB_REG_EN_BIT));
		for (int c = 0; c < NUM_CH; c++) begin
			val[c] = (c == 0) ? 8'h3F : 8'($urandom) & 8'h3F;
			wr(REG_CH_BASE + 8'(c), val[c]);
		end
		settle();
		for (int c = 0; c < NUM_CH; c++) begin
			chk("slave eq", {6'h00, val[c][1:0]}, {6'h00, chan_eq[c]});
			chk("slave swing", {5'h00, val[c][4:2]}, {5'h00, chan_swing[c]});
			chk("slave term", {6'h00, val[c][5] ? 2'h0 : lv[PIN_RECEIVER_DETECT_PIN]}, {6'h00, chan_term[c]});
		end
		$display("test slave mode done");
		@(posedge sys_clk);
		power_down_pin <= 1'b1;
		settle();
		chk("enable", 8'h00, chan_enable);
		for (int c = 0; c < NUM_CH; c++)
			rd(REG_CH_BASE + 8'(c), val[c], "kept setting");
		@(posedge sys_clk);
		power_down_pin <= 1'b0;
		$display("test power down done");
		wr(REG_OVR, 8'h8C);
		@(posedge sys_clk);
		strap_cmp[PIN_RECEIVER_DETECT_PIN] <= cmp_of(2'h0);
		settle();
		for (int c = 0; c < NUM_CH; c++)
			chk("termination", val[c][5] ? 8'h00 : 8'h03, {6'h00, chan_term[c]});
		$display("test override done");
		@(posedge sys_clk);
		smbus_mode_select <= 2'h1;
		wait_st(6, 20);
		link_image_source_inst.send_byte(REG_CH_BASE + 8'h02);
		link_image_source_inst.send_byte(8'h15);
		link_image_source_inst.send_byte(LOAD_END_ADDR);
		wait_st(5, 40);
		chk("bus clock", 8'h00, {6'h00, scl_out, scl_oe});
		rd(REG_CH_BASE + 8'h02, 8'h15, "loaded value");
		$display("test load done");
		@(posedge sys_clk);
		smbus_mode_select <= 2'h2;
		settle();
		@(posedge sys_clk);
		smbus_mode_select <= 2'h1;
		wait_st(6, 20);
		link_image_source_inst.send_byte(REG_CH_BASE);
		wait_st(1, LOAD_SIM + 100);
		chk("hung bus clock", 8'h00, {7'h00, scl_oe});
		$display("test failed load done");
		@(posedge sys_clk);
		rst_n <= 1'b0;
		settle();
		chk("ready in reset", 8'h00, {7'h00, device_ready});
		@(posedge sys_clk);
		rst_n <= 1'b1;
		wait_st(0, POR_SIM + 10);
		$display("test second reset done");
		final_report();
	end
endmodule // test_repeater_config_source_select
`default_nettype wire
